// ---- tcm_pkg.sv ----
// Purpose: shared constants, types and mode decode for the timer channels
// Assumes: 8 channels, 16-bit counter, 8-bit byte offset window
// Notes: control, interrupt status and mask offsets are local choices
package tcm_pkg;
    localparam int NCH = 8;
    localparam int CNT_W = 16;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam logic [AW-1:0] STC_OFF = 8'h0C;
    localparam logic [AW-1:0] CV_OFF = 8'h10;
    localparam logic [AW-1:0] CH_STEP = 8'h08;
    localparam logic [AW-1:0] CTRL_OFF = 8'h80;
    localparam logic [AW-1:0] IST_OFF = 8'h84;
    localparam logic [AW-1:0] IMSK_OFF = 8'h88;
    // Channel status/control fields
    localparam int FLAG_BIT = 7;
    localparam int IE_BIT = 6;
    localparam int MS_LSB = 4;
    localparam int ES_LSB = 2;
    // Module control fields
    localparam int WPD_BIT = 0;
    localparam int CPWM_BIT = 1;
    localparam int COMB_LSB = 8;
    localparam int DCAP_LSB = 12;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] ES_OFF = 2'h0;
    localparam logic [1:0] ES_RISE = 2'h1;
    localparam logic [1:0] ES_FALL = 2'h2;
    localparam logic [1:0] ES_BOTH = 2'h3;

    typedef enum logic [2:0] {
        TCM_GPIO = 3'h0,
        TCM_ICAP = 3'h1,
        TCM_OCMP = 3'h3,
        TCM_EPWM = 3'h2,
        TCM_CPWM = 3'h6,
        TCM_COMB = 3'h7,
        TCM_DCAP = 3'h5
    } tcm_mode_t;

    function automatic tcm_mode_t tcm_chan_mode(input logic [1:0] ms,
        input logic [1:0] es, input logic comb, input logic dcap,
        input logic centre);
        if (es == ES_OFF)
            return TCM_GPIO;
        else if (dcap && !comb && !centre)
            return TCM_DCAP;
        else if (comb && !centre)
            return TCM_COMB;
        else if (centre)
            return TCM_CPWM;
        else if (ms[1])
            return TCM_EPWM;
        else if (ms[0])
            return TCM_OCMP;
        else
            return TCM_ICAP;
    endfunction : tcm_chan_mode

    function automatic logic tcm_is_capture(input tcm_mode_t m);
        return (m == TCM_ICAP) || (m == TCM_DCAP);
    endfunction : tcm_is_capture
endpackage : tcm_pkg

// ---- tcm_ahb_slave.sv ----
// Purpose: AHB-Lite slave front end, zero wait states
// Assumes: single word transfers only; response always OKAY
// Notes: writes commit at the end of their data phase
`timescale 1ns/1ps
`default_nettype none
module tcm_ahb_slave
    import tcm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [tcm_pkg::DW-1:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [tcm_pkg::DW-1:0] hrdata,
    // Register side
    output logic rdReq,
    output logic [tcm_pkg::AW-1:0] rdAddr,
    input wire logic [tcm_pkg::DW-1:0] rdData,
    output logic wrEn,
    output logic [tcm_pkg::AW-1:0] wrAddr,
    output logic [tcm_pkg::DW-1:0] wrData
);
    import tcm_pkg::*;

    typedef struct packed {
        logic wrPend;
        logic [AW-1:0] wrAddr;
        logic [DW-1:0] rdata;
        logic ready;
    } tcm_ahb_t;

    tcm_ahb_t state_r, state_nxt;
    logic addrPhase;

    // Only word transfers exist, so size is not decoded
    assign addrPhase = hsel && hready && (htrans[1] == HTRANS_NONSEQ[1]);
    assign rdReq = addrPhase && !hwrite;
    assign rdAddr = haddr[AW-1:0];
    assign wrEn = state_r.wrPend;
    assign wrAddr = state_r.wrAddr;
    assign wrData = hwdata;
    assign hreadyout = state_r.ready;
    assign hresp = 1'b0;
    assign hrdata = state_r.rdata;

    always_comb begin
        state_nxt = state_r;
        state_nxt.ready = 1'b1;
        state_nxt.wrPend = addrPhase && hwrite;
        if (addrPhase)
            state_nxt.wrAddr = haddr[AW-1:0];
        if (rdReq)
            state_nxt.rdata = rdData;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            state_r <= '{wrPend: 1'b0, wrAddr: '0, rdata: '0, ready: 1'b1};
        else
            state_r <= state_nxt;
    end
endmodule : tcm_ahb_slave
`default_nettype wire

// ---- tcm_channel.sv ----
// Purpose: one timer channel: capture, compare and PWM pin logic
// Assumes: counter and its tick, wrap and direction come from outside
// Notes: pin outputs are registered; input pin is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module tcm_channel
    import tcm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Counter
    input wire logic [tcm_pkg::CNT_W-1:0] cnt,
    input wire logic cntTick,
    input wire logic cntWrap,
    input wire logic cntUp,
    // Configuration
    input wire logic [1:0] modeSel,
    input wire logic [1:0] edgeSel,
    input wire logic combine,
    input wire logic dualEdge,
    input wire logic centre,
    input wire logic flag,
    input wire logic matchA,
    input wire logic matchB,
    // Pin
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    // Events
    output logic evt,
    output logic cap,
    output logic [tcm_pkg::CNT_W-1:0] capVal
);
    import tcm_pkg::*;

    typedef struct packed {
        logic pinPrev;
        logic outLvl;
        logic oe;
        logic evt;
        logic cap;
        logic [CNT_W-1:0] capVal;
    } tcm_chan_t;

    tcm_chan_t state_r, state_nxt;
    tcm_mode_t mode;
    logic edgeHit;
    logic hitA;
    logic hitB;

    assign mode = tcm_chan_mode(modeSel, edgeSel, combine, dualEdge, centre);
    assign edgeHit = (edgeSel[0] && pinIn && !state_r.pinPrev) ||
                     (edgeSel[1] && !pinIn && state_r.pinPrev);
    assign hitA = cntTick && matchA;
    assign hitB = cntTick && matchB;
    assign pinOut = state_r.outLvl;
    assign pinOe = state_r.oe;
    assign evt = state_r.evt;
    assign cap = state_r.cap;
    assign capVal = state_r.capVal;

    always_comb begin
        state_nxt = state_r;
        state_nxt.pinPrev = pinIn;
        state_nxt.evt = 1'b0;
        state_nxt.cap = 1'b0;
        // Pin driven only in output functions
        state_nxt.oe = (mode != TCM_GPIO) && !tcm_is_capture(mode);
        unique case (mode)
            TCM_GPIO: begin
                state_nxt.outLvl = 1'b0;
            end
            TCM_ICAP: begin
                if (edgeHit) begin
                    state_nxt.evt = 1'b1;
                    state_nxt.cap = 1'b1;
                    state_nxt.capVal = cnt;
                end
            end
            TCM_DCAP: begin
                // One-shot waits for the flag to be cleared before rearming
                if (edgeHit && (modeSel[0] || !flag)) begin
                    state_nxt.evt = 1'b1;
                    state_nxt.cap = 1'b1;
                    state_nxt.capVal = cnt;
                end
            end
            TCM_OCMP: begin
                if (hitA) begin
                    state_nxt.evt = 1'b1;
                    unique case (edgeSel)
                        ES_RISE: state_nxt.outLvl = !state_r.outLvl;
                        ES_FALL: state_nxt.outLvl = 1'b0;
                        default: state_nxt.outLvl = 1'b1;
                    endcase
                end
            end
            TCM_EPWM: begin
                if (cntTick && cntWrap)
                    state_nxt.outLvl = !edgeSel[0];
                if (hitA) begin
                    state_nxt.evt = 1'b1;
                    state_nxt.outLvl = edgeSel[0];
                end
            end
            TCM_CPWM: begin
                if (hitA) begin
                    state_nxt.evt = 1'b1;
                    state_nxt.outLvl = cntUp ? edgeSel[0] : !edgeSel[0];
                end
            end
            default: begin
                // Combined pair: first match opens, second closes
                if (hitA) begin
                    state_nxt.evt = 1'b1;
                    state_nxt.outLvl = !edgeSel[0];
                end
                if (hitB)
                    state_nxt.outLvl = edgeSel[0];
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end
endmodule : tcm_channel
`default_nettype wire

// ---- tcm_timer_channels.sv ----
// Purpose: eight timer channels with status/control, value and irq regs
// Assumes: AHB-Lite register access; counter supplied from outside
// Notes: a read in the cycle after a write to the same word sees old data
// Behaviour
// - Edge select 00 releases pin to GPIO
// - Output compare toggles, clears or sets on match
// - Edge or centre aligned PWM polarity by edge select
// - Dual edge: one-shot or continuous by mode bit
// - Dual edge edge select picks detected edges
// - Channel event sets flag bit 7
// - Flag clears by read while set, then write 0
// - Writing 1 to flag does nothing
// - Event between read and write keeps flag
// - Interrupt enable bit 6 gates channel interrupt
// - Mode and edge bits writable only when unprotected
// - Bits 31-8 and 1-0 read zero
// - Status/control at 0xC plus 8 times channel
// - Value register holds capture or match value
`timescale 1ns/1ps
`default_nettype none
module tcm_timer_channels
    import tcm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [tcm_pkg::DW-1:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [tcm_pkg::DW-1:0] hrdata,
    // Counter
    input wire logic [tcm_pkg::CNT_W-1:0] cnt,
    input wire logic cntTick,
    input wire logic cntWrap,
    input wire logic cntUp,
    // Channel pins
    input wire logic [tcm_pkg::NCH-1:0] chanIn,
    output logic [tcm_pkg::NCH-1:0] chanOut,
    output logic [tcm_pkg::NCH-1:0] chanOe,
    // Interrupt
    output logic irq
);
    import tcm_pkg::*;

    typedef struct packed {
        logic [NCH-1:0] flag;
        logic [NCH-1:0] armed;
        logic [NCH-1:0] ie;
        logic [NCH-1:0][1:0] ms;
        logic [NCH-1:0][1:0] es;
        logic [NCH-1:0][CNT_W-1:0] cv;
        logic wpd;
        logic centre;
        logic [NCH/2-1:0] comb;
        logic [NCH/2-1:0] dcap;
        logic [NCH-1:0] irqSt;
        logic [NCH-1:0] irqMsk;
        logic irq;
    } tcm_main_t;

    tcm_main_t state_r, state_nxt;

    logic rdReq;
    logic [AW-1:0] rdAddr;
    logic [DW-1:0] rdData;
    logic wrEn;
    logic [AW-1:0] wrAddr;
    logic [DW-1:0] wrData;
    logic [NCH-1:0] match;
    logic [NCH-1:0] evt;
    logic [NCH-1:0] cap;
    logic [NCH-1:0][CNT_W-1:0] capVal;

    function automatic logic [AW-1:0] stcAddr(input int ch);
        return STC_OFF + AW'(ch) * CH_STEP;
    endfunction : stcAddr

    function automatic logic [AW-1:0] cvAddr(input int ch);
        return CV_OFF + AW'(ch) * CH_STEP;
    endfunction : cvAddr

    function automatic tcm_mode_t modeOf(input tcm_main_t s, input int ch);
        return tcm_chan_mode(s.ms[ch], s.es[ch], s.comb[ch/2],
                             s.dcap[ch/2], s.centre);
    endfunction : modeOf

    tcm_ahb_slave u_bus (
        .clk(clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rdReq(rdReq),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData)
    );

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign match[g] = (cnt == state_r.cv[g]);
        tcm_channel u_ch (
            .clk(clk),
            .rst(rst),
            .cnt(cnt),
            .cntTick(cntTick),
            .cntWrap(cntWrap),
            .cntUp(cntUp),
            .modeSel(state_r.ms[g]),
            .edgeSel(state_r.es[g]),
            .combine(state_r.comb[g/2]),
            .dualEdge(state_r.dcap[g/2]),
            .centre(state_r.centre),
            .flag(state_r.flag[g]),
            // Combined pairs share the even channel's match as opener
            .matchA(state_r.comb[g/2] ? match[g & ~1] : match[g]),
            .matchB(match[g | 1]),
            .pinIn(chanIn[g]),
            .pinOut(chanOut[g]),
            .pinOe(chanOe[g]),
            .evt(evt[g]),
            .cap(cap[g]),
            .capVal(capVal[g])
        );
    end

    // Read mux; unmapped words and reserved bits read zero
    always_comb begin
        rdData = '0;
        for (int i = 0; i < NCH; i++) begin
            if (rdAddr == stcAddr(i)) begin
                rdData[FLAG_BIT] = state_r.flag[i];
                rdData[IE_BIT] = state_r.ie[i];
                rdData[MS_LSB +: 2] = state_r.ms[i];
                rdData[ES_LSB +: 2] = state_r.es[i];
            end
            if (rdAddr == cvAddr(i))
                rdData[CNT_W-1:0] = state_r.cv[i];
        end
        if (rdAddr == CTRL_OFF) begin
            rdData[WPD_BIT] = state_r.wpd;
            rdData[CPWM_BIT] = state_r.centre;
            rdData[COMB_LSB +: NCH/2] = state_r.comb;
            rdData[DCAP_LSB +: NCH/2] = state_r.dcap;
        end
        if (rdAddr == IST_OFF)
            rdData[NCH-1:0] = state_r.irqSt;
        if (rdAddr == IMSK_OFF)
            rdData[NCH-1:0] = state_r.irqMsk;
    end

    always_comb begin
        state_nxt = state_r;
        for (int i = 0; i < NCH; i++) begin
            // Reading the word while the flag is set arms the clear
            if (rdReq && rdAddr == stcAddr(i) && state_r.flag[i])
                state_nxt.armed[i] = 1'b1;
            if (wrEn && wrAddr == stcAddr(i)) begin
                state_nxt.ie[i] = wrData[IE_BIT];
                if (state_r.wpd) begin
                    state_nxt.ms[i] = wrData[MS_LSB +: 2];
                    state_nxt.es[i] = wrData[ES_LSB +: 2];
                end
                // A one leaves the flag alone; any write ends the sequence
                if (!wrData[FLAG_BIT] && state_r.armed[i])
                    state_nxt.flag[i] = 1'b0;
                state_nxt.armed[i] = 1'b0;
            end
            // Capture modes own the value word, software writes dropped
            if (wrEn && wrAddr == cvAddr(i) && !tcm_is_capture(modeOf(state_r, i)))
                state_nxt.cv[i] = wrData[CNT_W-1:0];
            if (cap[i])
                state_nxt.cv[i] = capVal[i];
            // Event wins over a clear in the same cycle and disarms it
            if (evt[i]) begin
                state_nxt.flag[i] = 1'b1;
                state_nxt.armed[i] = 1'b0;
                state_nxt.irqSt[i] = 1'b1;
            end
        end
        if (wrEn && wrAddr == CTRL_OFF) begin
            state_nxt.wpd = wrData[WPD_BIT];
            if (state_r.wpd)
                state_nxt.centre = wrData[CPWM_BIT];
            state_nxt.comb = wrData[COMB_LSB +: NCH/2];
            state_nxt.dcap = wrData[DCAP_LSB +: NCH/2];
        end
        if (wrEn && wrAddr == IST_OFF)
            state_nxt.irqSt = state_r.irqSt & ~wrData[NCH-1:0] | evt;
        if (wrEn && wrAddr == IMSK_OFF)
            state_nxt.irqMsk = wrData[NCH-1:0];
        state_nxt.irq = |(state_nxt.irqSt & state_nxt.irqMsk & state_nxt.ie);
    end

    assign irq = state_r.irq;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end
endmodule : tcm_timer_channels
`default_nettype wire

// ---- tcm_properties.sv ----
// Purpose: port level properties of the timer channel block
// Assumes: zero wait state bus, one clock domain
// Notes: causes are tracked as saturating cycle counts since they occur
`timescale 1ns/1ps
`default_nettype none
module tcm_properties
    import tcm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [tcm_pkg::DW-1:0] hrdata,
    // Counter, pins and interrupt
    input wire logic cntTick,
    input wire logic [tcm_pkg::NCH-1:0] chanIn,
    input wire logic [tcm_pkg::NCH-1:0] chanOut,
    input wire logic [tcm_pkg::NCH-1:0] chanOe,
    input wire logic irq
);
    import tcm_pkg::*;

    typedef struct packed {
        logic [NCH-1:0] pinPrev;
        logic [3:0] evtAgo;
        logic [3:0] tickAgo;
        logic [3:0] wrAgo;
    } tcm_chk_t;
    tcm_chk_t chk_r;
    tcm_chk_t chk_nxt;
    logic take;
    assign take = hsel && hready && htrans[1];

    function automatic logic [3:0] sat(input logic [3:0] v);
        return (v == 4'hF) ? v : v + 4'h1;
    endfunction : sat

    always_comb begin
        chk_nxt = chk_r;
        chk_nxt.pinPrev = chanIn;
        chk_nxt.evtAgo = sat(chk_r.evtAgo);
        chk_nxt.tickAgo = sat(chk_r.tickAgo);
        chk_nxt.wrAgo = sat(chk_r.wrAgo);
        if (cntTick)
            chk_nxt.tickAgo = 4'h0;
        if (take && hwrite)
            chk_nxt.wrAgo = 4'h0;
        if (cntTick || take || chanIn != chk_r.pinPrev)
            chk_nxt.evtAgo = 4'h0;
    end

    // Reset to long ago so nothing counts as a fresh cause
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            chk_r <= '1;
        else
            chk_r <= chk_nxt;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence sRdStc;
        take && !hwrite && haddr[7:0] >= STC_OFF && haddr[7:0] <= 8'h44
            && haddr[2:0] == 3'h4;
    endsequence
    sequence sRdFree;
        take && !hwrite && haddr[7:0] > IMSK_OFF;
    endsequence

    AST_READY_HIGH: assert property (hreadyout)
        else $error("bus slave inserted a wait state");
    AST_STC_RSVD: assert property (sRdStc |=>
        hrdata[31:8] == 24'h0 && hrdata[1:0] == 2'h0)
        else $error("reserved status bits read nonzero");
    AST_FREE_ZERO: assert property (sRdFree |=> hrdata == 32'h0)
        else $error("unmapped read returned data");
    AST_RDATA_HOLD: assert property (!(take && !hwrite) |=>
        $stable(hrdata))
        else $error("read data moved without a read");
    AST_OE_CAUSE: assert property ($changed(chanOe) |->
        chk_r.wrAgo <= 4'h3)
        else $error("pin enable moved without a write");
    AST_OUT_CAUSE: assert property ($changed(chanOut) |->
        chk_r.tickAgo <= 4'h2 || chk_r.wrAgo <= 4'h3)
        else $error("pin level moved without tick or write");
    AST_IRQ_RISE: assert property ($rose(irq) |->
        chk_r.evtAgo <= 4'h5)
        else $error("interrupt rose without an event");
    AST_IRQ_FALL: assert property ($fell(irq) |->
        chk_r.wrAgo <= 4'h4)
        else $error("interrupt fell without a write");
endmodule : tcm_properties

bind tcm_timer_channels tcm_properties tcm_properties_inst (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .cntTick(cntTick), .chanIn(chanIn),
    .chanOut(chanOut), .chanOe(chanOe), .irq(irq)
);
`default_nettype wire

// ---- tcm_pin_model.sv ----
// Purpose: outside drivers on the eight channel pins
// Assumes: pin levels are synchronous to the block clock
// Notes: no pull on the pins; the stimulus always drives a level
`timescale 1ns/1ps
`default_nettype none
module tcm_pin_model
    import tcm_pkg::*;
(
    // Stimulus
    input wire logic [tcm_pkg::NCH-1:0] drive,
    // Block side
    input wire logic [tcm_pkg::NCH-1:0] chanOut,
    input wire logic [tcm_pkg::NCH-1:0] chanOe,
    output logic [tcm_pkg::NCH-1:0] chanIn
);
    // Block wins while enabled, outside level returns when released
    assign chanIn = (chanOe & chanOut) | (~chanOe & drive);
endmodule : tcm_pin_model
`default_nettype wire

// ---- tcm_testbench.sv ----
// Purpose: bus and pin level test of the timer channel block
// Assumes: zero wait state slave; counter and pins driven here
// Notes: one idle cycle follows every transfer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tcm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] cnt = 16'h0;
    logic cntTick = 1'b0;
    logic cntWrap = 1'b0;
    logic cntUp = 1'b1;
    logic [NCH-1:0] drive = 8'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [NCH-1:0] chanIn;
    logic [NCH-1:0] chanOut;
    logic [NCH-1:0] chanOe;
    logic irq;
    logic [1:0] ocEs [3] = '{2'h2, 2'h3, 2'h1};
    int fail_count = 0;
    int checks = 0;

    always #4 clk = ~clk;

    tcm_timer_channels tcm_timer_channels_inst (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cnt(cnt),
        .cntTick(cntTick), .cntWrap(cntWrap), .cntUp(cntUp),
        .chanIn(chanIn), .chanOut(chanOut), .chanOe(chanOe), .irq(irq)
    );
    tcm_pin_model tcm_pin_model_inst (
        .drive(drive), .chanOut(chanOut), .chanOe(chanOe), .chanIn(chanIn)
    );

    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        // Same word read right after a write would see stale data
        @(posedge clk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask : rdChk

    task automatic tick(input logic [15:0] v, input logic w, input logic u);
        cnt <= v;
        cntWrap <= w;
        cntUp <= u;
        cntTick <= 1'b1;
        @(posedge clk);
        cntTick <= 1'b0;
        cntWrap <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : tick

    task automatic pin(input logic [7:0] v);
        drive <= v;
        repeat (4) @(posedge clk);
    endtask : pin

    task automatic irqChk(input logic e);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'(e));
    endtask : irqChk

    function automatic logic [7:0] at(input logic [7:0] b, input int i);
        return b + CH_STEP * 8'(i);
    endfunction : at

    initial begin
        #400000;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdChk(STC_OFF, 32'h0);
        chk(32'(hresp), 32'h0);
        rdChk(8'hFC, 32'h0);
        wr(STC_OFF, 32'h7C);
        rdChk(STC_OFF, 32'h40);
        wr(CTRL_OFF, 32'h1);
        for (int i = 0; i < NCH; i++) begin
            wr(at(STC_OFF, i), 32'hFFFFFFFF);
            rdChk(at(STC_OFF, i), 32'h7C);
            wr(at(STC_OFF, i), 32'h44);
        end
        wr(at(STC_OFF, 1), 32'h08);
        wr(at(STC_OFF, 2), 32'h4C);
        cnt <= 16'h1234;
        pin(8'hFF);
        rdChk(STC_OFF, 32'hC4);
        rdChk(at(STC_OFF, 1), 32'h08);
        rdChk(CV_OFF, 32'h1234);
        irqChk(1'b0);
        wr(IMSK_OFF, 32'h2);
        pin(8'h00);
        rdChk(at(STC_OFF, 1), 32'h88);
        rdChk(at(STC_OFF, 2), 32'hCC);
        irqChk(1'b0);
        wr(IMSK_OFF, 32'h1);
        irqChk(1'b1);
        wr(IST_OFF, 32'hFF);
        irqChk(1'b0);
        wr(STC_OFF, 32'hC4);
        rdChk(STC_OFF, 32'hC4);
        wr(STC_OFF, 32'h44);
        rdChk(STC_OFF, 32'h44);
        pin(8'hFF);
        wr(STC_OFF, 32'h44);
        rdChk(STC_OFF, 32'hC4);
        pin(8'h00);
        pin(8'hFF);
        wr(STC_OFF, 32'h44);
        rdChk(STC_OFF, 32'hC4);
        wr(STC_OFF, 32'h44);
        rdChk(STC_OFF, 32'h44);
        wr(at(STC_OFF, 3), 32'h18);
        wr(at(CV_OFF, 3), 32'h50);
        for (int i = 0; i < 3; i++) begin
            wr(at(STC_OFF, 3), 32'h10 | 32'(ocEs[i]) << 2);
            tick(16'h50, 1'b0, 1'b1);
            chk(32'(chanOut[3]), 32'(i == 1));
        end
        chk(32'(chanOe[3]), 32'h1);
        wr(at(STC_OFF, 3), 32'h10);
        irqChk(1'b1);
        chk(32'(chanOe[3]), 32'h0);
        wr(at(STC_OFF, 4), 32'h24);
        wr(at(CV_OFF, 4), 32'h30);
        for (int e = 1; e <= 2; e++) begin
            wr(at(STC_OFF, 4), 32'h20 | 32'(e) << 2);
            tick(16'h0, 1'b1, 1'b1);
            chk(32'(chanOut[4]), 32'(e[0] == 1'b0));
            tick(16'h30, 1'b0, 1'b1);
            chk(32'(chanOut[4]), 32'(e[0]));
        end
        wr(CTRL_OFF, 32'h3);
        tick(16'h30, 1'b0, 1'b0);
        chk(32'(chanOut[4]), 32'h1);
        tick(16'h30, 1'b0, 1'b1);
        chk(32'(chanOut[4]), 32'h0);
        wr(CTRL_OFF, 32'h401);
        wr(at(CV_OFF, 5), 32'h60);
        tick(16'h30, 1'b0, 1'b1);
        chk(32'(chanOut[4]), 32'h1);
        tick(16'h60, 1'b0, 1'b1);
        chk(32'(chanOut[4]), 32'h0);
        wr(CTRL_OFF, 32'h8001);
        wr(at(STC_OFF, 6), 32'h18);
        cnt <= 16'h0777;
        pin(8'h00);
        rdChk(at(CV_OFF, 6), 32'h0777);
        wr(at(STC_OFF, 6), 32'h08);
        cnt <= 16'h0888;
        pin(8'hFF);
        pin(8'h00);
        rdChk(at(CV_OFF, 6), 32'h0777);
        // Continuous dual edge on both edges, then port disabled
        wr(at(STC_OFF, 7), 32'h1C);
        chk(32'(chanOe[7]), 32'h0);
        cnt <= 16'h0999;
        pin(8'hFF);
        rdChk(at(CV_OFF, 7), 32'h0999);
        cnt <= 16'h0AAA;
        pin(8'h00);
        rdChk(at(CV_OFF, 7), 32'h0AAA);
        wr(at(STC_OFF, 7), 32'h10);
        cnt <= 16'h0BBB;
        pin(8'hFF);
        rdChk(at(CV_OFF, 7), 32'h0AAA);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
